// ---- core/pfc_params.svh ----
`ifndef PFC_PARAMS_SVH
`define PFC_PARAMS_SVH
// register byte offsets
`define PFC_OFF_DATA    8'h00
`define PFC_OFF_CTRL    8'h04
`define PFC_OFF_STAT    8'h08
`define PFC_OFF_LMARGIN 8'h0c
`define PFC_OFF_RMARGIN 8'h10
`define PFC_OFF_BARCODE 8'h14
// control fields
`define PFC_CTRL_BITIMG 0
`define PFC_CTRL_DW     1
`define PFC_CTRL_DH     2
`define PFC_CTRL_SP_LO  8
`define PFC_CTRL_SP_HI  15
`define PFC_SPACING_RST 8'h18
// status fields, 8 and 9 are write-one-to-clear
`define PFC_ST_ROT      0
`define PFC_ST_UPS      1
`define PFC_ST_TABLE    2
`define PFC_ST_BUSY     3
`define PFC_ST_MREJ     8
`define PFC_ST_BDROP    9
// command bytes
`define PFC_B_ESC       8'h1b
`define PFC_B_GS        8'h1d
`define PFC_B_LF        8'h0a
`define PFC_B_FDF       8'h4a
`define PFC_B_FDB       8'h4b
`define PFC_B_FLF       8'h64
`define PFC_B_FLB       8'h65
`define PFC_B_ROT       8'h56
`define PFC_B_TBL       8'h74
`define PFC_B_UPS       8'h7b
`define PFC_B_INTL      8'h52
`define PFC_B_LM        8'h46
`define PFC_B_RM        8'h57
`define PFC_B_CUT       8'h56
`define PFC_CUT_FULL0   8'h00
`define PFC_CUT_FULL1   8'h30
`define PFC_CUT_PART0   8'h01
`define PFC_CUT_PART1   8'h31
`define PFC_CUT_FFULL   8'h41
`define PFC_CUT_FPART   8'h42
// margin rules
`define PFC_MARGIN_SEP  17'd80
`define PFC_TEXT_MASK   16'hfffc
`define PFC_BIMG_MASK   16'hfff8
`endif

// ---- core/pfc_pkg.sv ----
package pfc_pkg;
    typedef enum logic [2:0] {P_IDLE, P_ESC, P_GS, P_ARG1, P_ARG2} pfc_parse_e;
    typedef enum logic [3:0] {C_FDF, C_FDB, C_FLF, C_FLB, C_ROT, C_TBL,
                              C_UPS, C_INTL, C_LM, C_RM, C_CUT} pfc_cmd_e;
    typedef enum logic [1:0] {A_IDLE, A_FEED, A_CUT} pfc_act_e;
    typedef struct packed {
        logic [7:0] code;
        logic       rot;
        logic [1:0] angle;
        logic       dw;
        logic       dh;
        logic       table_sel;
    } pfc_char_s;
    typedef struct packed {
        logic        req;
        logic        reverse;
        logic [15:0] dots;
    } pfc_feed_s;
endpackage : pfc_pkg

// ---- core/pfc_cmd_interp.sv ----
// Behaviour
// - 1B 4A n: flush pending line, then feed forward n dot lines.
// - 1B 4B n: flush pending line, then feed backward n dot lines.
// - 1B 64 n: flush, then feed forward n character lines.
// - 1B 65 n: flush, then feed backward n character lines.
// - 1B 56 n: n=1 turns text rotation on, n=0 turns it off.
// - rotation plus upside-down gives 270 degrees in total.
// - rotation affects text only, never graphics; no page mode.
// - while rotated, double-width and double-height swap.
// - rotation is tagged per character, so lines may mix.
// - 1B 74 n: bit 0 selects domestic or code page 437 table.
// - 1B 7B n: bit 0 upside-down, effective from next line start.
// - left margin command: flush, margin = n2*256 + n1.
// - text mode rounds margin down to multiple of 4.
// - bit-image mode rounds margin down to multiple of 8.
// - margins stay at least 80 dots apart; closer settings refused.
// - bar code wider than printable width is discarded.
// - right margin command follows the left margin handling.
// - cut mode 00 or 30: immediate full cut, no length byte.
// - cut mode 01 or 31: immediate partial cut, no length byte.
// - cut mode 41/42: feed length byte dots, then full/partial cut.
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "pfc_params.svh"
module pfc_cmd_interp
    import pfc_pkg::*;
#(
    parameter logic [15:0] PRINT_DOTS = 16'd576
)(
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [7:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output var  logic [31:0] wb_dat_out,
    output var  logic        wb_ack_out,
    input  wire logic        mech_busy_in,
    output var  logic        flush_out,
    output var  pfc_feed_s   feed_out,
    output var  logic        cut_req_out,
    output var  logic        cut_partial_out,
    output var  logic        char_valid_out,
    output var  pfc_char_s   char_out,
    output var  logic        barcode_req_out,
    output var  logic [15:0] barcode_dots_out
);

////////////////////////////////////////////////////////////////////////
// bus decode
logic        ack_q;
pfc_parse_e  pst_q;
pfc_act_e    act_q;
pfc_cmd_e    cmd_q;
logic [7:0]  arg1_q;
logic [7:0]  ctrl_sp_q;
logic [2:0]  ctrl_q;
logic        rot_q;
logic        ups_q;
logic        line_ups_q;
logic        line_open_q;
logic        tbl_q;
logic        mrej_q;
logic        bdrop_q;
logic [15:0] lm_q;
logic [15:0] rm_q;
logic [15:0] dots_q;
logic        rev_q;
logic        cut_pend_q;
logic        cut_part_q;

wire sel_data = wb_adr_in == `PFC_OFF_DATA;
wire sel_ctrl = wb_adr_in == `PFC_OFF_CTRL;
wire sel_stat = wb_adr_in == `PFC_OFF_STAT;
wire sel_lm   = wb_adr_in == `PFC_OFF_LMARGIN;
wire sel_rm   = wb_adr_in == `PFC_OFF_RMARGIN;
wire sel_bc   = wb_adr_in == `PFC_OFF_BARCODE;
// bytes are held off while a flush, feed or cut is still in progress
wire stall_w  = sel_data && wb_we_in && act_q != A_IDLE;
wire req_w    = wb_cyc_in && wb_stb_in;
wire take_w   = req_w && ack_q && wb_we_in;
wire byte_w   = take_w && sel_data && wb_sel_in[0];
wire [7:0] b  = wb_dat_in[7:0];
wire ctrl_w   = take_w && sel_ctrl;
wire stat_w   = take_w && sel_stat && wb_sel_in[1];
wire bc_w     = take_w && sel_bc;

wire [31:0] rd_w =
    sel_ctrl ? {16'h0000, ctrl_sp_q, 5'h00, ctrl_q} :
    sel_stat ? {22'h000000, bdrop_q, mrej_q, 4'h0,
                act_q != A_IDLE, tbl_q, ups_q, rot_q} :
    sel_lm   ? {16'h0000, lm_q} :
    sel_rm   ? {16'h0000, rm_q} : 32'h0000_0000;

////////////////////////////////////////////////////////////////////////
// parser decode
wire two_arg_w = cmd_q == C_LM || cmd_q == C_RM ||
                 (cmd_q == C_CUT && (b == `PFC_CUT_FFULL || b == `PFC_CUT_FPART));
wire done_w    = byte_w && ((pst_q == P_ARG1 && !two_arg_w) || pst_q == P_ARG2);
wire lm_cmd_w  = done_w && cmd_q == C_LM;
wire rm_cmd_w  = done_w && cmd_q == C_RM;
wire cut_cmd_w = done_w && cmd_q == C_CUT;
wire is_full_w = (pst_q == P_ARG1) ? (b == `PFC_CUT_FULL0 || b == `PFC_CUT_FULL1)
                                   : arg1_q == `PFC_CUT_FFULL;
wire is_part_w = (pst_q == P_ARG1) ? (b == `PFC_CUT_PART0 || b == `PFC_CUT_PART1)
                                   : arg1_q == `PFC_CUT_FPART;
wire fdot_w    = done_w && (cmd_q == C_FDF || cmd_q == C_FDB);
wire fline_w   = done_w && (cmd_q == C_FLF || cmd_q == C_FLB);
// both factors widened first so the product keeps all 16 bits on every tool
wire [15:0] line_dots_w = {8'h00, b} * {8'h00, ctrl_sp_q};
// margin position, quantised by print mode
wire [15:0] mraw_w = {b, arg1_q};
wire [15:0] mq_w   = ctrl_q[`PFC_CTRL_BITIMG] ? (mraw_w & `PFC_BIMG_MASK)
                                              : (mraw_w & `PFC_TEXT_MASK);
wire lm_ok_w  = {1'b0, rm_q} >= {1'b0, mq_w} + `PFC_MARGIN_SEP;
wire rm_ok_w  = {1'b0, mq_w} >= {1'b0, lm_q} + `PFC_MARGIN_SEP;
wire mset_w   = (lm_cmd_w && lm_ok_w) || (rm_cmd_w && rm_ok_w);
wire mrej_w   = (lm_cmd_w && !lm_ok_w) || (rm_cmd_w && !rm_ok_w);
wire act_go_w = fdot_w || fline_w || lm_cmd_w || rm_cmd_w ||
                (cut_cmd_w && (is_full_w || is_part_w));
wire bc_fit_w = {16'h0000, wb_dat_in[15:0]} <= {16'h0000, rm_q - lm_q};
wire char_w   = byte_w && pst_q == P_IDLE && b != `PFC_B_ESC && b != `PFC_B_GS;
// 90 from rotation adds to 180 from upside-down, so both together give code 3
wire [1:0] angle_w = {line_ups_q, rot_q};

////////////////////////////////////////////////////////////////////////
// wishbone slave: one wait state, longer for data writes while a flush, feed or cut is in progress
always_ff @(posedge clk_in or negedge rst_n_in)
begin
    if (!rst_n_in)
    begin
        ack_q      <= 1'b0;
        wb_dat_out <= 32'h0000_0000;
    end
    else
    begin
        ack_q      <= req_w && !ack_q && !stall_w;
        wb_dat_out <= rd_w;
    end
end
assign wb_ack_out = ack_q;

always_ff @(posedge clk_in or negedge rst_n_in)
begin
    if (!rst_n_in)
    begin
        ctrl_q    <= 3'h0;
        ctrl_sp_q <= `PFC_SPACING_RST;
    end
    else if (ctrl_w)
    begin
        ctrl_q    <= wb_dat_in[2:0];
        ctrl_sp_q <= wb_dat_in[`PFC_CTRL_SP_HI:`PFC_CTRL_SP_LO];
    end
end

// sticky flags: a new event wins over a clear in the same cycle
always_ff @(posedge clk_in or negedge rst_n_in)
begin
    if (!rst_n_in)
    begin
        mrej_q  <= 1'b0;
        bdrop_q <= 1'b0;
    end
    else
    begin
        mrej_q  <= mrej_w || (mrej_q && !(stat_w && wb_dat_in[`PFC_ST_MREJ]));
        bdrop_q <= (bc_w && !bc_fit_w) || (bdrop_q && !(stat_w && wb_dat_in[`PFC_ST_BDROP]));
    end
end

////////////////////////////////////////////////////////////////////////
// escape sequence parser
always_ff @(posedge clk_in or negedge rst_n_in)
begin
    if (!rst_n_in)
    begin
        pst_q  <= P_IDLE;
        cmd_q  <= C_FDF;
        arg1_q <= 8'h00;
    end
    else if (byte_w)
    begin
        unique case (pst_q)
            P_IDLE:
            begin
                if (b == `PFC_B_ESC)
                    pst_q <= P_ESC;
                else if (b == `PFC_B_GS)
                    pst_q <= P_GS;
            end
            P_ESC:
            begin
                pst_q <= P_ARG1;
                unique case (b)
                    `PFC_B_FDF:  cmd_q <= C_FDF;
                    `PFC_B_FDB:  cmd_q <= C_FDB;
                    `PFC_B_FLF:  cmd_q <= C_FLF;
                    `PFC_B_FLB:  cmd_q <= C_FLB;
                    `PFC_B_ROT:  cmd_q <= C_ROT;
                    `PFC_B_TBL:  cmd_q <= C_TBL;
                    `PFC_B_UPS:  cmd_q <= C_UPS;
                    `PFC_B_INTL: cmd_q <= C_INTL;
                    // other escapes belong to other blocks and are dropped here
                    default:     pst_q <= P_IDLE;
                endcase
            end
            P_GS:
            begin
                pst_q <= P_ARG1;
                unique case (b)
                    `PFC_B_LM:  cmd_q <= C_LM;
                    `PFC_B_RM:  cmd_q <= C_RM;
                    `PFC_B_CUT: cmd_q <= C_CUT;
                    default:    pst_q <= P_IDLE;
                endcase
            end
            P_ARG1:
            begin
                arg1_q <= b;
                pst_q  <= two_arg_w ? P_ARG2 : P_IDLE;
            end
            P_ARG2:
                pst_q <= P_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// format state
always_ff @(posedge clk_in or negedge rst_n_in)
begin
    if (!rst_n_in)
    begin
        rot_q <= 1'b0;
        ups_q <= 1'b0;
        tbl_q <= 1'b0;
        lm_q  <= 16'h0000;
        rm_q  <= PRINT_DOTS;
    end
    else
    begin
        if (done_w && cmd_q == C_ROT && b == 8'h01)
            rot_q <= 1'b1;
        else if (done_w && cmd_q == C_ROT && b == 8'h00)
            rot_q <= 1'b0;
        if (done_w && cmd_q == C_UPS)
            ups_q <= b[0];
        if (done_w && cmd_q == C_TBL)
            tbl_q <= b[0];
        if (lm_cmd_w && lm_ok_w)
            lm_q <= mq_w;
        if (rm_cmd_w && rm_ok_w)
            rm_q <= mq_w;
    end
end

// upside-down is taken only while no character of the line is pending
always_ff @(posedge clk_in or negedge rst_n_in)
begin
    if (!rst_n_in)
    begin
        line_open_q <= 1'b0;
        line_ups_q  <= 1'b0;
    end
    else
    begin
        if (flush_out || (char_w && b == `PFC_B_LF))
            line_open_q <= 1'b0;
        else if (char_w)
            line_open_q <= 1'b1;
        if (!line_open_q)
            line_ups_q <= ups_q;
    end
end

////////////////////////////////////////////////////////////////////////
// text output; graphics never see the rotation, it rides on each glyph
always_ff @(posedge clk_in or negedge rst_n_in)
begin
    if (!rst_n_in)
    begin
        char_valid_out <= 1'b0;
        char_out       <= '0;
    end
    else
    begin
        char_valid_out <= char_w;
        if (char_w)
        begin
            char_out.code      <= b;
            char_out.rot       <= rot_q;
            char_out.angle     <= angle_w;
            char_out.table_sel <= tbl_q;
            char_out.dw        <= rot_q ? ctrl_q[`PFC_CTRL_DH] : ctrl_q[`PFC_CTRL_DW];
            char_out.dh        <= rot_q ? ctrl_q[`PFC_CTRL_DW] : ctrl_q[`PFC_CTRL_DH];
        end
    end
end

always_ff @(posedge clk_in or negedge rst_n_in)
begin
    if (!rst_n_in)
    begin
        barcode_req_out  <= 1'b0;
        barcode_dots_out <= 16'h0000;
    end
    else
    begin
        barcode_req_out <= bc_w && bc_fit_w;
        if (bc_w)
            barcode_dots_out <= wb_dat_in[15:0];
    end
end

////////////////////////////////////////////////////////////////////////
// paper handling: flush first, then feed, then cut
always_ff @(posedge clk_in or negedge rst_n_in)
begin
    if (!rst_n_in)
    begin
        act_q      <= A_IDLE;
        dots_q     <= 16'h0000;
        rev_q      <= 1'b0;
        cut_pend_q <= 1'b0;
        cut_part_q <= 1'b0;
    end
    else
    begin
        unique case (act_q)
            A_IDLE:
            begin
                if (act_go_w)
                    act_q <= A_FEED;
                rev_q      <= cmd_q == C_FDB || cmd_q == C_FLB;
                cut_pend_q <= cut_cmd_w;
                cut_part_q <= is_part_w;
                if (fdot_w)
                    dots_q <= {8'h00, b};
                else if (fline_w)
                    dots_q <= line_dots_w;
                else if (cut_cmd_w && pst_q == P_ARG2)
                    dots_q <= {8'h00, b};
                else
                    dots_q <= 16'h0000;
            end
            A_FEED:
                if (!mech_busy_in)
                    act_q <= cut_pend_q ? A_CUT : A_IDLE;
            A_CUT:
                if (!mech_busy_in && !feed_out.req)
                    act_q <= A_IDLE;
        endcase
    end
end

always_ff @(posedge clk_in or negedge rst_n_in)
begin
    if (!rst_n_in)
    begin
        flush_out       <= 1'b0;
        feed_out        <= '0;
        cut_req_out     <= 1'b0;
        cut_partial_out <= 1'b0;
    end
    else
    begin
        flush_out    <= act_q == A_IDLE && act_go_w;
        feed_out.req <= act_q == A_FEED && !mech_busy_in && dots_q != 16'h0000;
        if (act_q == A_FEED)
        begin
            feed_out.dots    <= dots_q;
            feed_out.reverse <= rev_q;
        end
        cut_req_out <= act_q == A_CUT && !mech_busy_in && !feed_out.req;
        if (act_q == A_CUT)
            cut_partial_out <= cut_part_q;
    end
end

////////////////////////////////////////////////////////////////////////
// checks
sequence s_fdf;
    done_w && cmd_q == C_FDF;
endsequence
sequence s_feed_issue;
    flush_out && act_q == A_FEED;
endsequence
property p_fdf;
    @(posedge clk_in) disable iff (!rst_n_in)
    s_fdf |=> s_feed_issue ##0 (dots_q == {8'h00, $past(b)} && !rev_q);
endproperty
a_fdf: assert property (p_fdf) else $error("dot feed not staged");
property p_fdb;
    @(posedge clk_in) disable iff (!rst_n_in)
    done_w && cmd_q == C_FDB |=> s_feed_issue ##0 rev_q;
endproperty
a_fdb: assert property (p_fdb) else $error("reverse dot feed wrong");
property p_flf;
    @(posedge clk_in) disable iff (!rst_n_in)
    done_w && cmd_q == C_FLF |=> dots_q == {8'h00, $past(b)} * {8'h00, ctrl_sp_q};
endproperty
a_flf: assert property (p_flf) else $error("line feed count wrong");
property p_feed_zero;
    @(posedge clk_in) disable iff (!rst_n_in)
    feed_out.req |-> feed_out.dots != 16'h0000 && $past(act_q) == A_FEED;
endproperty
a_feed_zero: assert property (p_feed_zero) else $error("empty feed issued");
property p_swap;
    @(posedge clk_in) disable iff (!rst_n_in)
    char_w && rot_q |=> char_out.dh == $past(ctrl_q[`PFC_CTRL_DW]) && char_out.angle[0];
endproperty
a_swap: assert property (p_swap) else $error("rotated size not swapped");
property p_text_q;
    @(posedge clk_in) disable iff (!rst_n_in)
    lm_cmd_w && lm_ok_w && !ctrl_q[0] |=> lm_q[1:0] == 2'b00;
endproperty
a_text_q: assert property (p_text_q) else $error("text margin not multiple of 4");
property p_bimg_q;
    @(posedge clk_in) disable iff (!rst_n_in)
    rm_cmd_w && rm_ok_w && ctrl_q[0] |=> rm_q[2:0] == 3'b000;
endproperty
a_bimg_q: assert property (p_bimg_q) else $error("image margin not multiple of 8");
property p_sep;
    @(posedge clk_in) disable iff (!rst_n_in)
    {1'b0, rm_q} >= {1'b0, lm_q} + `PFC_MARGIN_SEP;
endproperty
a_sep: assert property (p_sep) else $error("margins too close");
property p_bc;
    @(posedge clk_in) disable iff (!rst_n_in)
    bc_w && !bc_fit_w |=> !barcode_req_out && bdrop_q;
endproperty
a_bc: assert property (p_bc) else $error("oversize bar code passed");
property p_full;
    @(posedge clk_in) disable iff (!rst_n_in)
    cut_cmd_w && pst_q == P_ARG1 && is_full_w |=> act_q == A_FEED && cut_pend_q && !cut_part_q;
endproperty
a_full: assert property (p_full) else $error("full cut not staged");
property p_hold;
    @(posedge clk_in) disable iff (!rst_n_in)
    byte_w && pst_q != P_IDLE |=> !char_valid_out;
endproperty
a_hold: assert property (p_hold) else $error("argument leaked as text");

endmodule : pfc_cmd_interp
`default_nettype wire

// ---- bench/pfc_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// host side of the register bus: one classic cycle at a time, held until ack
module pfc_host_model (
    input  wire logic        clk_in,
    input  wire logic        ack_in,
    input  wire logic [31:0] rd_in,
    output var  logic        cyc_out,
    output var  logic        we_out,
    output var  logic [7:0]  adr_out,
    output var  logic [3:0]  sel_out,
    output var  logic [31:0] wd_out
);
    int to_cnt = 0;

    initial
    begin
        cyc_out = 1'b0;
        we_out = 1'b0;
        adr_out = 8'h00;
        sel_out = 4'h0;
        wd_out = 32'h0;
    end

    // data writes may stall behind paper motion, so the wait is long but bounded
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_in);
        cyc_out <= 1'b1;
        we_out <= w;
        adr_out <= a;
        sel_out <= s;
        wd_out <= d;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (ack_in !== 1'b1 && n < 5000);
        r = rd_in;
        cyc_out <= 1'b0;
        we_out <= 1'b0;
        wd_out <= ~d;
        if (n >= 5000)
            to_cnt++;
    endtask : xfer
endmodule : pfc_host_model
`default_nettype wire

// ---- bench/pfc_cmd_interp_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module pfc_cmd_interp_test
    import pfc_pkg::*;
;
    logic        clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        cyc, we, ack, flush, cut, cutp, cv, bq;
    logic        busy = 1'b0;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wd, rd_d;
    logic [15:0] bd;
    pfc_feed_s   feed;
    pfc_char_s   ch;
    logic [31:0] exp_q[$], obs_q[$];
    logic [7:0]  cm[6] = '{8'h00, 8'h30, 8'h01, 8'h31, 8'h41, 8'h42};
    int          error_cnt = 0, tests_run = 0, cyc_n = 0, bcnt = 0;
    int          lm = 0, rm = 576, sp = 24;
    bit          rot, ups_q, ups_l, st, tbl, dw, dh, bim, mrej, bdrop;

    pfc_host_model host (.clk_in(clk_in), .ack_in(ack), .rd_in(rd_d), .cyc_out(cyc), .we_out(we),
                         .adr_out(adr), .sel_out(sel), .wd_out(wd));
    pfc_cmd_interp #(.PRINT_DOTS(16'd576)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc),
        .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wd), .wb_dat_out(rd_d),
        .wb_ack_out(ack), .mech_busy_in(busy), .flush_out(flush), .feed_out(feed), .cut_req_out(cut),
        .cut_partial_out(cutp), .char_valid_out(cv), .char_out(ch), .barcode_req_out(bq),
        .barcode_dots_out(bd));

    initial
    begin
        forever #2 clk_in = ~clk_in;
    end

    ////////////////////////////////////////////////////////////
    // mechanism: busy from the cycle after a request, for a random stretch
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            busy <= 1'b0;
        else if (feed.req === 1'b1 || cut === 1'b1)
        begin
            busy <= 1'b1;
            bcnt <= $urandom_range(6, 1);
        end
        else if (bcnt > 0)
            bcnt <= bcnt - 1;
        else
            busy <= 1'b0;
    end

    always @(posedge clk_in)
    begin
        if (flush === 1'b1) obs_q.push_back(32'h1000_0000);
        if (feed.req === 1'b1) obs_q.push_back({4'h2, 11'h0, feed.reverse, feed.dots});
        if (cut === 1'b1) obs_q.push_back({4'h3, 27'h0, cutp});
        if (cv === 1'b1) obs_q.push_back({4'h4, 14'h0, ch});
        if (bq === 1'b1) obs_q.push_back({4'h5, 12'h0, bd});
        cyc_n++;
        if (cyc_n == 80000)
        begin
            error_cnt++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic final_report;
        error_cnt += host.to_cnt;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (e !== g)
        begin
            $display("Error at %0t: expected %h got %h", $time, e, g);
            error_cnt++;
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        host.xfer(1'b1, a, d, 4'h3, r);
    endtask : wr

    task automatic s2(input logic [7:0] a, input logic [7:0] b);
        wr(8'h00, {24'h0, a});
        wr(8'h00, {24'h0, b});
    endtask : s2

    task automatic s3(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        s2(a, b);
        wr(8'h00, {24'h0, c});
    endtask : s3

    task automatic ctl(input bit b, input bit w, input bit h);
        bim = b;
        dw = w;
        dh = h;
        wr(8'h04, {16'h0, 8'(sp), 5'h0, h, w, b});
    endtask : ctl

    task automatic fl;
        exp_q.push_back(32'h1000_0000);
        st = 0;
    endtask : fl

    task automatic paper(input bit rev, input int n, input bit c, input bit p);
        fl();
        if (n[15:0] != 16'h0)
            exp_q.push_back({4'h2, 11'h0, rev, n[15:0]});
        if (c)
            exp_q.push_back({4'h3, 27'h0, p});
    endtask : paper

    // upside-down is taken into a line only at its first character
    task automatic chr(input logic [7:0] b);
        wr(8'h00, {24'h0, b});
        if (!st)
            ups_l = ups_q;
        st = 1;
        exp_q.push_back({4'h4, 14'h0, b, rot, ups_l, rot, rot ? dh : dw, rot ? dw : dh, tbl});
        if (b == 8'h0a)
            st = 0;
    endtask : chr

    task automatic mrg(input bit r, input logic [7:0] n1, input logic [7:0] n2);
        int v;
        int nl;
        int nr;
        s3(8'h1d, r ? 8'h57 : 8'h46, n1);
        wr(8'h00, {24'h0, n2});
        v = {n2, n1} & (bim ? 16'hfff8 : 16'hfffc);
        nl = r ? lm : v;
        nr = r ? v : rm;
        if (nr - nl >= 80)
        begin
            lm = nl;
            rm = nr;
        end
        else
            mrej = 1;
        fl();
    endtask : mrg

    task automatic bc(input int w);
        wr(8'h14, 32'(w));
        if (w <= rm - lm)
            exp_q.push_back({4'h5, 12'h0, w[15:0]});
        else
            bdrop = 1;
    endtask : bc

    task automatic settle;
        logic [31:0] r;
        int n;
        n = 0;
        do
        begin
            host.xfer(1'b0, 8'h08, 32'h0, 4'hf, r);
            n++;
        end
        while (r[3] !== 1'b0 && n < 500);
        chk({22'h0, bdrop, mrej, 5'h0, tbl, ups_q, rot}, r);
        host.xfer(1'b0, 8'h0c, 32'h0, 4'hf, r);
        chk(32'(lm), r);
        host.xfer(1'b0, 8'h10, 32'h0, 4'hf, r);
        chk(32'(rm), r);
        chk(32'(exp_q.size()), 32'(obs_q.size()));
        while (exp_q.size() > 0 && obs_q.size() > 0)
            chk(exp_q.pop_front(), obs_q.pop_front());
        exp_q.delete();
        obs_q.delete();
    endtask : settle

    ////////////////////////////////////////////////////////////
    initial
    begin
        int i;
        int n;
        logic [31:0] r;
        void'($urandom(15760));
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        host.xfer(1'b0, 8'h04, 32'h0, 4'hf, r);
        chk(32'h1800, r);
        host.xfer(1'b0, 8'h20, 32'h0, 4'hf, r);
        chk(32'h0, r);
        settle();
        s2(8'h1b, 8'h4a);
        chk(32'h0, 32'(obs_q.size()));
        wr(8'h00, 32'hff);
        paper(0, 255, 0, 0);
        settle();
        for (i = 0; i < 6; i++)
        begin
            n = (i == 0) ? 0 : (i == 1) ? 255 : $urandom_range(254, 1);
            s3(8'h1b, i[0] ? 8'h4b : 8'h4a, n[7:0]);
            paper(i[0], n, 0, 0);
            settle();
        end
        for (i = 0; i < 4; i++)
        begin
            sp = $urandom_range(255, 1);
            ctl(0, 0, 0);
            n = (i == 0) ? 0 : $urandom_range(255, 1);
            s3(8'h1b, i[0] ? 8'h65 : 8'h64, n[7:0]);
            paper(i[0], n * sp, 0, 0);
            settle();
        end
        for (i = 0; i < 6; i++)
        begin
            n = $urandom_range(255, 0);
            s3(8'h1d, 8'h56, cm[i]);
            if (i < 4)
                paper(0, 0, 1, cm[i][0]);
            else
            begin
                wr(8'h00, {24'h0, n[7:0]});
                paper(0, n, 1, i == 5);
            end
            settle();
        end
        s3(8'h1d, 8'h56, 8'h55);
        chr(8'h41);
        s3(8'h1b, 8'h56, 8'h01);
        rot = 1;
        chr(8'h42);
        ctl(0, 1, 0);
        chr(8'h43);
        ctl(0, 0, 1);
        chr(8'h44);
        chr(8'h0a);
        s3(8'h1b, 8'h7b, 8'h01);
        ups_q = 1;
        chr(8'h45);
        s3(8'h1b, 8'h56, 8'h00);
        rot = 0;
        chr(8'h46);
        s3(8'h1b, 8'h7b, 8'h00);
        ups_q = 0;
        chr(8'h47);
        chr(8'h0a);
        chr(8'h48);
        s3(8'h1b, 8'h74, 8'h03);
        tbl = 1;
        chr(8'h49);
        settle();
        s3(8'h1b, 8'h74, 8'h02);
        tbl = 0;
        s3(8'h1b, 8'h52, 8'h05);
        s2(8'h1b, 8'h99);
        for (i = 0; i < 8; i++)
            chr(8'($urandom_range(8'h7e, 8'h20)));
        settle();
        ctl(0, 0, 0);
        mrg(0, 8'h07, 8'h00);
        mrg(1, 8'h23, 8'h01);
        mrg(0, 8'hd8, 8'h00);
        settle();
        mrg(0, 8'hd0, 8'h00);
        bc(80);
        bc(81);
        settle();
        wr(8'h08, 32'h300);
        mrej = 0;
        bdrop = 0;
        ctl(1, 0, 0);
        mrg(0, 8'h0f, 8'h00);
        mrg(1, 8'h2f, 8'h01);
        settle();
        final_report();
    end
endmodule : pfc_cmd_interp_test
`default_nettype wire
